//--- hw/pbm_ctrl.sv
/*
 * mode selection, button timing, hiccup, latch-off and charge sequencing.
 * assumes digital comparator flags, brought onto core_clk by a two-stage synchroniser; analog loops are outside.
 */
`timescale 1ns/1ps
module pbm_ctrl import pbm_pkg::*; #(
    parameter bit LAMP_VARIANT = 1'b0,
    parameter int TICK_DIV_P = TICK_DIV,
    parameter int DEB_P = DEB_TICKS,
    parameter int TRAN_P = TRAN_TICKS,
    parameter int OFF_P = OFF_TICKS,
    parameter int LAMP_P = LAMP_TICKS,
    parameter int HICCUP_P = HICCUP_TICKS,
    parameter int LIGHT_P = LIGHT_TICKS
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire pbm_in_t pins,
    output pbm_out_t ctl
);
    typedef struct packed {
        pbm_in_t s1;
        pbm_in_t s2;
        logic [15:0] div;
        logic tick;
        pbm_mode_t mode;
        pbm_mode_t target;
        pbm_chg_t chg;
        logic boost_on;
        logic lamp;
        logic latch;
        logic hiccup;
        logic btn_done;
        logic [CW-1:0] gap_cnt;
        logic [CW-1:0] btn_cnt;
        logic [CW-1:0] hic_cnt;
        logic [CW-1:0] ll_cnt;
        pbm_out_t o;
    } pbm_state_t;

    pbm_state_t r, next_r;
    pbm_in_t s;
    pbm_mode_t want;

    // synchronised inputs, second stage only
    assign s = r.s2;

    // requested mode from pins and latches
    always_comb begin
        if (s.input_supply) begin
            want = PBM_CHARGE;
        end else if (!s.standby_select_pin && r.boost_on && !r.latch) begin
            want = PBM_BOOST;
        end else begin
            want = PBM_HZ;
        end
    end

    // next-state logic
    always_comb begin
        next_r = r;
        next_r.s1 = pins;
        next_r.s2 = r.s1;
        next_r.tick = 1'b0;
        if (r.div == 16'(TICK_DIV_P - 1)) begin
            next_r.div = 16'h0000;
            next_r.tick = 1'b1;
        end else begin
            next_r.div = r.div + 16'h0001;
        end
        // latch-off clears only when input supply appears
        if (s.input_supply) begin
            next_r.latch = 1'b0;
        end else if (r.mode == PBM_BOOST && s.bat_latch_low) begin
            next_r.latch = 1'b1;
            next_r.boost_on = 1'b0;
        end
        // button press timing
        if (s.button_input) begin
            next_r.btn_cnt = '0;
            next_r.btn_done = 1'b0;
        end else if (r.tick && !r.btn_done) begin
            next_r.btn_cnt = r.btn_cnt + CW'(1);
            if (!s.standby_select_pin && !r.boost_on && !r.latch
                    && r.btn_cnt == CW'(DEB_P - 1)) begin
                next_r.boost_on = 1'b1;
                if (!LAMP_VARIANT) begin
                    next_r.btn_done = 1'b1;
                end
            end
            if (!LAMP_VARIANT && r.boost_on && r.btn_cnt == CW'(OFF_P - 1)) begin
                next_r.boost_on = 1'b0;
                next_r.btn_done = 1'b1;
            end
            if (LAMP_VARIANT && r.btn_cnt == CW'(LAMP_P - 1)) begin
                next_r.lamp = !r.lamp;
                next_r.btn_done = 1'b1;
            end
        end
        if (r.latch || s.standby_select_pin) begin
            next_r.lamp = 1'b0;
        end
        // light-load auto off
        if (r.mode != PBM_BOOST || !s.light_load) begin
            next_r.ll_cnt = '0;
        end else if (r.tick) begin
            next_r.ll_cnt = r.ll_cnt + CW'(1);
            if (r.ll_cnt == CW'(LIGHT_P - 1)) begin
                next_r.boost_on = 1'b0;
                next_r.ll_cnt = '0;
            end
        end
        // hiccup on output undervoltage
        if (r.mode != PBM_CHARGE) begin
            next_r.hiccup = 1'b0;
            next_r.hic_cnt = '0;
        end else if (!r.hiccup && s.vout_low) begin
            next_r.hiccup = 1'b1;
            next_r.hic_cnt = '0;
        end else if (r.hiccup && r.tick) begin
            next_r.hic_cnt = r.hic_cnt + CW'(1);
            if (r.hic_cnt == CW'(HICCUP_P - 1)) begin
                next_r.hiccup = 1'b0;
            end
        end
        // mode machine with mandatory gap between charge and boost
        case (r.mode)
            PBM_HZ: begin
                if (want != PBM_HZ) begin
                    next_r.mode = want;
                end
            end
            PBM_CHARGE, PBM_BOOST: begin
                if (want != r.mode) begin
                    if (want == PBM_HZ) begin
                        next_r.mode = PBM_HZ;
                    end else begin
                        next_r.mode = PBM_GAP;
                        next_r.target = want;
                        next_r.gap_cnt = '0;
                    end
                end
            end
            PBM_GAP: begin
                if (r.tick) begin
                    next_r.gap_cnt = r.gap_cnt + CW'(1);
                    if (r.gap_cnt == CW'(TRAN_P - 1)) begin
                        next_r.mode = (want == r.target) ? want : PBM_HZ;
                    end
                end
            end
            default: next_r.mode = PBM_HZ;
        endcase
        // charge sequencer
        if (r.mode != PBM_CHARGE) begin
            next_r.chg = PBM_PRE;
        end else begin
            case (r.chg)
                PBM_PRE: if (s.bat_above_pre) next_r.chg = PBM_FAST;
                PBM_FAST: if (s.bat_at_term) next_r.chg = PBM_TOP;
                PBM_TOP: if (s.cur_below_eoc) next_r.chg = PBM_EOC;
                PBM_EOC: if (s.bat_recharge) next_r.chg = PBM_FAST;
                default: next_r.chg = PBM_PRE;
            endcase
        end
        // registered outputs
        next_r.o = '0;
        next_r.o.latched_off = next_r.latch;
        next_r.o.lamp_driver_pin = next_r.lamp;
        case (next_r.mode)
            PBM_CHARGE: begin
                next_r.o.input_pass_switch = !next_r.hiccup;
                next_r.o.converter_high_switch = 1'b1;
                next_r.o.converter_low_switch = 1'b1;
                next_r.o.buck_mode = 1'b1;
                case (next_r.chg)
                    PBM_PRE: next_r.o.charge_current_set_pin = CUR_PRE;
                    PBM_FAST: next_r.o.charge_current_set_pin = CUR_FAST;
                    PBM_TOP: next_r.o.charge_current_set_pin = CUR_CV;
                    default: next_r.o.charge_current_set_pin = CUR_OFF;
                endcase
            end
            PBM_BOOST: begin
                next_r.o.converter_high_switch = 1'b1;
                next_r.o.converter_low_switch = 1'b1;
                next_r.o.boost_mode = 1'b1;
                next_r.o.reverse_block = 1'b1;
            end
            default: begin
                next_r.o.reverse_block = 1'b1;
            end
        endcase
    end

    // state register, synchronous reset
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            r <= '0;
            r.mode <= PBM_HZ;
            r.target <= PBM_HZ;
            r.chg <= PBM_PRE;
            r.s1.button_input <= 1'b1;
            r.s2.button_input <= 1'b1;
            r.s1.standby_select_pin <= 1'b1;
            r.s2.standby_select_pin <= 1'b1;
            r.o.reverse_block <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign ctl = r.o;

    property p_hz_off;
        @(posedge core_clk) disable iff (!reset_n)
        (r.mode == PBM_HZ || r.mode == PBM_GAP) |-> (ctl.input_pass_switch == 1'b0
            && ctl.converter_high_switch == 1'b0 && ctl.converter_low_switch == 1'b0);
    endproperty
    a_hz_off: assert property (p_hz_off) else $error("switch on in idle");

    property p_gap;
        @(posedge core_clk) disable iff (!reset_n)
        (r.mode == PBM_GAP && r.gap_cnt != CW'(TRAN_P - 1)) |=> r.mode == PBM_GAP;
    endproperty
    a_gap: assert property (p_gap) else $error("gap ended early");

    property p_no_direct;
        @(posedge core_clk) disable iff (!reset_n)
        (r.mode == PBM_CHARGE) |=> r.mode != PBM_BOOST;
    endproperty
    a_no_direct: assert property (p_no_direct) else $error("direct charge to boost");

    property p_boost_pass;
        @(posedge core_clk) disable iff (!reset_n)
        ctl.boost_mode |-> (!ctl.input_pass_switch && ctl.reverse_block);
    endproperty
    a_boost_pass: assert property (p_boost_pass) else $error("pass on in boost");

    property p_charge_sel;
        @(posedge core_clk) disable iff (!reset_n)
        (r.mode != PBM_GAP && s.input_supply) |=> (r.mode == PBM_CHARGE
            || r.mode == PBM_GAP);
    endproperty
    a_charge_sel: assert property (p_charge_sel) else $error("charge not chosen");

    property p_pre_cur;
        @(posedge core_clk) disable iff (!reset_n)
        (ctl.buck_mode && r.chg == PBM_PRE) |-> ctl.charge_current_set_pin == CUR_PRE;
    endproperty
    a_pre_cur: assert property (p_pre_cur) else $error("wrong precharge level");

    property p_order;
        @(posedge core_clk) disable iff (!reset_n)
        (r.chg == PBM_PRE && r.mode == PBM_CHARGE) |=> r.chg inside {PBM_PRE, PBM_FAST};
    endproperty
    a_order: assert property (p_order) else $error("charge state skipped");

    property p_latch;
        @(posedge core_clk) disable iff (!reset_n)
        (r.latch && !s.input_supply) |=> (r.latch && r.mode != PBM_BOOST);
    endproperty
    a_latch: assert property (p_latch) else $error("latch-off left");

    property p_hiccup;
        @(posedge core_clk) disable iff (!reset_n)
        (r.mode == PBM_CHARGE && !r.hiccup && s.vout_low && next_r.mode == PBM_CHARGE)
            |=> ##1 !ctl.input_pass_switch;
    endproperty
    a_hiccup: assert property (p_hiccup) else $error("no hiccup");

    c_boost: cover property (@(posedge core_clk) disable iff (!reset_n) ctl.boost_mode);
    c_gap: cover property (@(posedge core_clk) disable iff (!reset_n)
        r.mode == PBM_GAP ##1 r.mode == PBM_CHARGE);
    c_eoc: cover property (@(posedge core_clk) disable iff (!reset_n) r.chg == PBM_EOC);
    c_lamp: cover property (@(posedge core_clk) disable iff (!reset_n) ctl.lamp_driver_pin);
endmodule

//--- inc/pbm_pkg.sv
/*
 * constants, state types and port bundles for the power-bank mode and charge controller.
 * assumes a free-running 200 MHz core clock and comparator flags already digital.
 */
package pbm_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int TICK_US = 100;
    localparam int TICK_DIV = CLK_HZ / 1_000_000 * TICK_US;
    localparam int DEB_MS = 30;
    localparam int TRAN_MS = 2000;
    localparam int OFF_MS = 1500;
    localparam int LAMP_MS = 3000;
    localparam int HICCUP_MS = 2000;
    localparam int LIGHT_MS = 16000;
    localparam int DEB_TICKS = DEB_MS * 1000 / TICK_US + 1;
    localparam int TRAN_TICKS = TRAN_MS * 1000 / TICK_US;
    localparam int OFF_TICKS = OFF_MS * 1000 / TICK_US + 1;
    localparam int LAMP_TICKS = LAMP_MS * 1000 / TICK_US;
    localparam int HICCUP_TICKS = HICCUP_MS * 1000 / TICK_US;
    localparam int LIGHT_TICKS = LIGHT_MS * 1000 / TICK_US;
    localparam int CW = 18;
    localparam logic [1:0] CUR_OFF = 2'h0;
    localparam logic [1:0] CUR_PRE = 2'h1;
    localparam logic [1:0] CUR_FAST = 2'h2;
    localparam logic [1:0] CUR_CV = 2'h3;

    typedef enum logic [1:0] {PBM_HZ, PBM_GAP, PBM_CHARGE, PBM_BOOST} pbm_mode_t;
    typedef enum logic [1:0] {PBM_PRE, PBM_FAST, PBM_TOP, PBM_EOC} pbm_chg_t;

    typedef struct packed {
        logic input_supply;
        logic standby_select_pin;
        logic button_input;
        logic vout_low;
        logic bat_latch_low;
        logic bat_above_pre;
        logic bat_at_term;
        logic cur_below_eoc;
        logic bat_recharge;
        logic light_load;
    } pbm_in_t;

    typedef struct packed {
        logic input_pass_switch;
        logic converter_high_switch;
        logic converter_low_switch;
        logic buck_mode;
        logic boost_mode;
        logic reverse_block;
        logic lamp_driver_pin;
        logic [1:0] charge_current_set_pin;
        logic latched_off;
    } pbm_out_t;
endpackage

//--- verif/pbm_ctrl_tb_top.sv
/*
 * self-checking bench for the mode and charge controller, base and lamp variants.
 * assumes shortened tick counts; inputs change at falling edges through the far-side model.
 */
`timescale 1ns/1ps
module pbm_ctrl_tb_top import pbm_pkg::*;;
    localparam int TK = 4;
    localparam int DEB = 3;
    localparam int OFF = 5;
    localparam int LAMP = 6;
    localparam int TRAN = 4;
    localparam int HIC = 4;
    localparam int LIGHT = 8;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic press = 1'b0;
    logic overload = 1'b0;
    pbm_in_t want = '0;
    pbm_in_t pins;
    pbm_out_t ctl;
    pbm_out_t ctl_lamp;
    pbm_in_t row_in [6];
    logic row_pass [6];
    logic [1:0] row_cur [6];
    int bad_count = 0;
    int samples_checked = 0;
    int n;

    pbm_far_side i_pbm_far_side (.want(want), .press(press), .overload(overload), .pins(pins));
    pbm_ctrl #(.LAMP_VARIANT(1'b0), .TICK_DIV_P(TK), .DEB_P(DEB), .TRAN_P(TRAN), .OFF_P(OFF),
        .LAMP_P(LAMP), .HICCUP_P(HIC), .LIGHT_P(LIGHT)) i_pbm_ctrl (.core_clk(core_clk),
        .reset_n(reset_n), .pins(pins), .ctl(ctl));
    pbm_ctrl #(.LAMP_VARIANT(1'b1), .TICK_DIV_P(TK), .DEB_P(DEB), .TRAN_P(TRAN), .OFF_P(OFF),
        .LAMP_P(LAMP), .HICCUP_P(HIC), .LIGHT_P(LIGHT)) i_pbm_ctrl_lamp (.core_clk(core_clk),
        .reset_n(reset_n), .pins(pins), .ctl(ctl_lamp));

    // 200 MHz clock
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic cyc(input int k);
        repeat (k) @(negedge core_clk);
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_cur(input string what, input logic [1:0] exp, input logic [1:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // hold the button until the base instance reports boost, then release
    task automatic press_until_boost();
        press = 1'b1;
        cyc(1);
        for (n = 0; n < 200 && ctl.boost_mode !== 1'b1; n++) cyc(1);
        press = 1'b0;
        cyc(8);
    endtask

    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // hang guard, well beyond the few hundred cycles of the run
    initial begin
        #100000;
        bad_count++;
        $display("MISMATCH watchdog expected done seen hang");
        stop_test();
    end

    initial begin
        // charge walk then storage: supply, select, flags; expected pass switch and current
        row_in = '{10'h300, 10'h310, 10'h318, 10'h31C, 10'h312, 10'h100};
        row_pass = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        row_cur = '{CUR_PRE, CUR_FAST, CUR_CV, CUR_OFF, CUR_FAST, CUR_OFF};
        cyc(2);
        chk_bit("reset pass", 1'b0, ctl.input_pass_switch);
        chk_bit("reset revblk", 1'b1, ctl.reverse_block);
        reset_n = 1'b1;
        cyc(2);
        for (int r = 0; r < 6; r++) begin
            want = row_in[r];
            cyc(12);
            chk_bit("row pass", row_pass[r], ctl.input_pass_switch);
            chk_bit("row buck", row_pass[r], ctl.buck_mode);
            chk_bit("row low sw", row_pass[r], ctl.converter_low_switch);
            chk_cur("row cur", row_cur[r], ctl.charge_current_set_pin);
        end
        // select low: a short press is too short, a long one starts boost
        want.standby_select_pin = 1'b0;
        cyc(4);
        press = 1'b1;
        cyc(5);
        press = 1'b0;
        cyc(20);
        chk_bit("short press", 1'b0, ctl.boost_mode);
        press_until_boost();
        chk_bit("boost on", 1'b1, ctl.boost_mode);
        chk_bit("boost pass", 1'b0, ctl.input_pass_switch);
        chk_bit("boost revblk", 1'b1, ctl.reverse_block);
        // light load switches boost off after its detect time
        want.light_load = 1'b1;
        for (n = 0; n < 100 && ctl.boost_mode !== 1'b0; n++) cyc(1);
        chk_bit("light off", 1'b0, ctl.boost_mode);
        chk_bit("light wait", 1'b1, n >= (LIGHT - 1) * TK);
        want.light_load = 1'b0;
        // long presses: base turns boost off then back on, lamp variant toggles the lamp
        press_until_boost();
        press = 1'b1;
        cyc(40);
        press = 1'b0;
        cyc(8);
        chk_bit("long press off", 1'b0, ctl.boost_mode);
        chk_bit("lamp on", 1'b1, ctl_lamp.lamp_driver_pin);
        press = 1'b1;
        cyc(40);
        press = 1'b0;
        cyc(8);
        chk_bit("lamp off", 1'b0, ctl_lamp.lamp_driver_pin);
        // boost to charge passes through an all-off gap
        for (n = 0; n < 200 && ctl.boost_mode !== 1'b1; n++) cyc(1);
        want.input_supply = 1'b1;
        cyc(8);
        chk_bit("gap hi sw", 1'b0, ctl.converter_high_switch);
        chk_bit("gap pass", 1'b0, ctl.input_pass_switch);
        for (n = 0; n < 200 && ctl.input_pass_switch !== 1'b1; n++) cyc(1);
        chk_bit("gap length", 1'b1, n >= (TRAN - 1) * TK - 8);
        chk_bit("charge after gap", 1'b1, ctl.buck_mode);
        // overload trips the pass switch, retry after the hiccup time
        overload = 1'b1;
        for (n = 0; n < 40 && ctl.input_pass_switch !== 1'b0; n++) cyc(1);
        overload = 1'b0;
        chk_bit("hiccup off", 1'b0, ctl.input_pass_switch);
        for (n = 0; n < 200 && ctl.input_pass_switch !== 1'b1; n++) cyc(1);
        chk_bit("hiccup retry", 1'b1, ctl.input_pass_switch);
        chk_bit("hiccup wait", 1'b1, n >= (HIC - 1) * TK);
        // low battery in boost latches off until the supply returns
        want.input_supply = 1'b0;
        cyc(40);
        press_until_boost();
        want.bat_latch_low = 1'b1;
        for (n = 0; n < 40 && ctl.latched_off !== 1'b1; n++) cyc(1);
        want.bat_latch_low = 1'b0;
        cyc(2);
        chk_bit("latched", 1'b1, ctl.latched_off);
        chk_bit("latch hi sw", 1'b0, ctl.converter_high_switch);
        press = 1'b1;
        cyc(20);
        press = 1'b0;
        cyc(8);
        chk_bit("latch holds", 1'b0, ctl.boost_mode);
        want.input_supply = 1'b1;
        for (n = 0; n < 200 && ctl.input_pass_switch !== 1'b1; n++) cyc(1);
        chk_bit("latch cleared", 1'b0, ctl.latched_off);
        // reset in mid-charge drops every switch
        reset_n = 1'b0;
        cyc(2);
        chk_bit("rst pass", 1'b0, ctl.input_pass_switch);
        chk_cur("rst cur", CUR_OFF, ctl.charge_current_set_pin);
        reset_n = 1'b1;
        cyc(2);
        chk_bit("rst hold", 1'b0, ctl.input_pass_switch);
        cyc(4);
        chk_bit("rst resume", 1'b1, ctl.input_pass_switch);
        stop_test();
    end
endmodule

//--- verif/pbm_far_side.sv
/*
 * far-side stand-in: comparator flags, output overload and a push button with pull-up.
 * assumes the bench changes its requests just after falling clock edges.
 */
`timescale 1ns/1ps
module pbm_far_side import pbm_pkg::*; (
    input wire pbm_in_t want,
    input wire logic press,
    input wire logic overload,
    output pbm_in_t pins
);
    // comparator flags follow the requested analog state
    always_comb begin
        pins = want;
        pins.button_input = ~press; // pull-up, a press pulls the pin low
        pins.vout_low = overload; // rail under the hiccup trip
    end
endmodule
